// >>> bsc_pkg.sv
/*
 constants for the boot strap configuration capture block:
 register offsets, field positions, reset values and counts.
 assumes a 32-bit apb register bus and one 100 MHz clock.

*/
package bsc_pkg;
   localparam int STRAP_W = 29;
   localparam logic [28:0] STRAP_RESET = 29'h014A454;
   localparam int BIT_VEC_HI = 0;
   localparam int BIT_BIG_END = 1;
   localparam int BIT_FP_EN = 2;
   localparam int BIT_MP_SEL = 3;
   localparam int BIT_ST_ALIAS = 4;
   localparam int BIT_DY_ALIAS = 5;
   localparam int BIT_BR_MAP = 6;
   localparam int BIT_USE_PLL = 10;
   localparam int BIT_PLL_BYP = 11;
   localparam int BIT_PLL_SFB = 12;
   localparam int BIT_DIV_LO = 13;
   localparam int BIT_MISCA_LO = 7;
   localparam int BIT_MISCB_LO = 15;
   localparam logic [31:0] VEC_BASE_LOW = 32'h00000000;
   localparam logic [31:0] VEC_BASE_HIGH = 32'hFFFF0000;
   localparam logic [7:0] OFS_CAPTURED = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_PADS = 8'h0C;
   localparam int CTRL_LIVE = 0;
   localparam int CTRL_SAMPLE = 1;
   localparam int CTRL_CLEAR = 2;
   localparam int STAT_RESV = 0;
   localparam int STAT_IN_RST = 1;
   localparam int STAT_TAKEN = 2;
   localparam int STAT_CNT_LO = 8;
   localparam int CNT_W = 8;
   typedef enum logic [1:0] {
      ALIAS_NONE = 2'b00,
      ALIAS_STATIC = 2'b01,
      ALIAS_RESERVED = 2'b10,
      ALIAS_EXPANSION = 2'b11
   } bsc_alias_t;
endpackage

// >>> bsc_reg_if.sv
/*
 interface carrying register accesses from the apb slave to the core.
 assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface bsc_reg_if;
   logic wr_en;
   logic rd_en;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic err;
   modport slave (output wr_en, output rd_en, output addr, output wdata,
      input rdata, input err);
   modport core (input wr_en, input rd_en, input addr, input wdata,
      output rdata, output err);
endinterface
`default_nettype wire

// >>> bsc_edge_detect.sv
/*
 rising edge detector turning a synchronous level into a one-cycle pulse.
 assumes the level is already synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module bsc_edge_detect
   import bsc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // level in, pulse out
   input wire logic level_in,
   output logic rise_pulse
);
   logic prev_reg;
   logic rise_reg;
   wire rise_next = level_in & ~prev_reg;

   // a level already high at reset release is not an edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_reg <= 1'b1;
         rise_reg <= 1'b0;
      end else begin
         prev_reg <= level_in;
         rise_reg <= rise_next;
      end
   end

   assign rise_pulse = rise_reg;
endmodule
`default_nettype wire

// >>> bsc_apb_slave.sv
/*
 apb slave front end: one wait state, then pready with data or error.
 assumes apb3 signalling and a core that decodes over bsc_reg_if.
*/
`timescale 1ns/1ns
`default_nettype none
module bsc_apb_slave
   import bsc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // core side
   bsc_reg_if.slave rif
);
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   // first access cycle loads the answer, second completes
   wire access_start = psel & penable & ~pready_reg;
   wire access_done = psel & penable & pready_reg;

   assign rif.addr = paddr;
   assign rif.wdata = pwdata;
   assign rif.wr_en = access_done & pwrite;
   assign rif.rd_en = access_done & ~pwrite;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         pready_reg <= access_start;
         pslverr_reg <= access_start & rif.err;
         prdata_reg <= (access_start & ~pwrite) ? rif.rdata : 32'h00000000;
      end
   end

   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign prdata = prdata_reg;
endmodule
`default_nettype wire

// >>> bsc_strap_capture.sv
/*
 boot strap configuration capture: samples the strap pads into a store,
 holds them as configuration outputs and decodes them for consumers.
 assumes pads and strobes are synchronous to clk; reset_n is this
 block's own reset, chip_reset_n the reset of the rest of the chip.
*/
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module bsc_strap_capture
   import bsc_pkg::*;
#(
   parameter int WIDTH = STRAP_W,
   parameter logic [28:0] RESET_VALUE = STRAP_RESET
)
(
   // clock and own reset
   input wire logic clk,
   input wire logic reset_n,
   // strap sampling control
   input wire logic [WIDTH-1:0] strap_input_bus,
   input wire logic strap_sample_clock,
   input wire logic strap_clear_n,
   input wire logic chip_reset_n,
   // apb register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // processor configuration
   output logic vector_base_high_sel,
   output logic [31:0] vector_base_addr,
   output logic big_endian_init_sel,
   output logic fp_coproc_enable,
   // memory system configuration
   output logic multiport_static_sel,
   output logic static_alias_enable,
   output logic dynamic_alias_enable,
   output logic [1:0] alias_target,
   output logic bridge_map_sel,
   // clock configuration
   output logic use_pll_sel,
   output logic pll_bypass_sel,
   output logic pll_short_feedback_sel,
   output logic [1:0] bus_clock_div_sel,
   output logic [2:0] bus_clock_divisor,
   // straps for consumers elsewhere
   output logic [2:0] strap_misc_low,
   output logic [13:0] strap_misc_high,
   // chip running with captured mode
   output logic config_in_force
);

   // divisor is the field plus one
   function automatic logic [2:0] div_of(input logic [1:0] f);
      div_of = {1'b0, f} + 3'h1;
   endfunction

   // alias decode; reserved combination kept visible, not masked
   function automatic bsc_alias_t alias_of(input logic st, input logic dy);
      alias_of = bsc_alias_t'({dy, st});
   endfunction

   function automatic logic [31:0] vec_of(input logic hi);
      vec_of = hi ? VEC_BASE_HIGH : VEC_BASE_LOW;
   endfunction

   bsc_reg_if rif ();

   bsc_apb_slave u_apb (
      .clk(clk),
      .reset_n(reset_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .rif(rif)
   );

   logic sample_pulse;

   bsc_edge_detect u_edge (
      .clk(clk),
      .reset_n(reset_n),
      .level_in(strap_sample_clock),
      .rise_pulse(sample_pulse)
   );

   // state
   logic [WIDTH-1:0] store_reg;
   logic [WIDTH-1:0] store_next;
   logic live_reg;
   logic resv_seen_reg;
   logic taken_reg;
   logic [CNT_W-1:0] count_reg;
   logic chip_in_reset_reg;
   logic in_force_reg;
   logic [31:0] vec_addr_reg;
   logic [2:0] divisor_reg;
   bsc_alias_t alias_reg;

   // register decode
   wire hit_captured = (rif.addr == OFS_CAPTURED);
   wire hit_ctrl = (rif.addr == OFS_CTRL);
   wire hit_status = (rif.addr == OFS_STATUS);
   wire hit_pads = (rif.addr == OFS_PADS);
   wire hit_any = hit_captured | hit_ctrl | hit_status | hit_pads;
   wire wr_ctrl = rif.wr_en & hit_ctrl;
   wire wr_status = rif.wr_en & hit_status;

   // software commands are one-shot, not stored
   wire sw_sample = wr_ctrl & rif.wdata[CTRL_SAMPLE];
   wire sw_clear = wr_ctrl & rif.wdata[CTRL_CLEAR];

   // capture only while the chip is held in reset, unless live mode set
   wire capture_gate = chip_in_reset_reg | live_reg;
   wire do_capture = (sample_pulse | sw_sample) & capture_gate;
   wire do_clear = ~strap_clear_n | sw_clear;

   // clear beats capture; otherwise the store just holds
   assign store_next = do_clear ? RESET_VALUE :
      (do_capture ? strap_input_bus : store_reg);

   wire next_resv = store_next[BIT_DY_ALIAS] & ~store_next[BIT_ST_ALIAS];
   wire resv_set = do_capture & ~do_clear & next_resv;
   wire resv_clr = wr_status & rif.wdata[STAT_RESV];

   // read mux
   wire [31:0] ctrl_view = {31'h00000000, live_reg};
   wire [31:0] status_view = {16'h0000, count_reg, 5'h00,
      taken_reg, chip_in_reset_reg, resv_seen_reg};
   wire [31:0] captured_view = {3'h0, store_reg};
   wire [31:0] pads_view = {3'h0, strap_input_bus};

   assign rif.rdata = hit_captured ? captured_view :
      hit_ctrl ? ctrl_view :
      hit_status ? status_view :
      hit_pads ? pads_view : 32'h00000000;
   assign rif.err = ~hit_any;

   // own reset, independent of chip_reset_n; reset value is a usable mode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         store_reg <= RESET_VALUE;
      end else begin
         store_reg <= store_next;
      end
   end

   // derived outputs follow the store with no extra delay
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         vec_addr_reg <= VEC_BASE_LOW;
         divisor_reg <= 3'h2;
         alias_reg <= ALIAS_STATIC;
      end else begin
         vec_addr_reg <= vec_of(store_next[BIT_VEC_HI]);
         divisor_reg <= div_of(store_next[BIT_DIV_LO +: 2]);
         alias_reg <= alias_of(store_next[BIT_ST_ALIAS],
            store_next[BIT_DY_ALIAS]);
      end
   end

   // chip reset level and live mode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         chip_in_reset_reg <= 1'b1;
         in_force_reg <= 1'b0;
         live_reg <= 1'b0;
      end else begin
         chip_in_reset_reg <= ~chip_reset_n;
         in_force_reg <= chip_reset_n;
         if (wr_ctrl) begin
            live_reg <= rif.wdata[CTRL_LIVE];
         end
      end
   end

   // sticky reserved-combination flag: a set wins over a clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         resv_seen_reg <= 1'b0;
      end else if (resv_set) begin
         resv_seen_reg <= 1'b1;
      end else if (resv_clr) begin
         resv_seen_reg <= 1'b0;
      end
   end

   // capture bookkeeping; count saturates rather than wraps
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         taken_reg <= 1'b0;
         count_reg <= '0;
      end else if (do_clear) begin
         taken_reg <= 1'b0;
      end else if (do_capture) begin
         taken_reg <= 1'b1;
         if (count_reg != {CNT_W{1'b1}}) begin
            count_reg <= count_reg + 8'h01;
         end
      end
   end

   // configuration outputs from the store; vector base, alias target and divisor from their decode registers
   assign vector_base_high_sel = store_reg[BIT_VEC_HI];
   assign vector_base_addr = vec_addr_reg;
   assign big_endian_init_sel = store_reg[BIT_BIG_END];
   assign fp_coproc_enable = store_reg[BIT_FP_EN];
   assign multiport_static_sel = store_reg[BIT_MP_SEL];
   assign static_alias_enable = store_reg[BIT_ST_ALIAS];
   assign dynamic_alias_enable = store_reg[BIT_DY_ALIAS];
   assign alias_target = alias_reg;
   assign bridge_map_sel = store_reg[BIT_BR_MAP];
   assign use_pll_sel = store_reg[BIT_USE_PLL];
   assign pll_bypass_sel = store_reg[BIT_PLL_BYP];
   assign pll_short_feedback_sel = store_reg[BIT_PLL_SFB];
   assign bus_clock_div_sel = store_reg[BIT_DIV_LO +: 2];
   assign bus_clock_divisor = divisor_reg;
   assign strap_misc_low = store_reg[BIT_MISCA_LO +: 3];
   assign strap_misc_high = store_reg[BIT_MISCB_LO +: 14];
   // consumers may trust the outputs once the chip leaves reset
   assign config_in_force = in_force_reg;
endmodule
`default_nettype wire

// >>> bsc_strap_source.sv
/*
 board strap source: holds strap values on the pads and pulses the strobe.
 assumes the bench raises go for one cycle with the wanted value.
*/
`timescale 1ns/1ns
`default_nettype none
module bsc_strap_source
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // request
   input wire logic go,
   input wire logic [28:0] want,
   // pads
   output logic [28:0] pads,
   output logic strobe
);
   logic [2:0] step_reg;
   // the reserved alias combination is never put on the pads
   wire logic [28:0] legal = {want[28:5], want[4] | want[5], want[3:0]};
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         step_reg <= 3'h0;
         pads <= 29'h0000000;
         strobe <= 1'b0;
      end else if (go) begin
         step_reg <= 3'h1;
         pads <= legal;
      end else if (step_reg != 3'h0) begin
         step_reg <= step_reg + 3'h1;
         strobe <= (step_reg <= 3'h3);
         // pads move after the frame; alias pair kept legal
         if (step_reg == 3'h6) pads <= {~pads[28:6], 2'b01, ~pads[3:0]};
      end
   end
endmodule
`default_nettype wire

// >>> bsc_strap_capture_checker.sv
/*
 checker for the strap capture block: capture, clear, hold and decode.
 assumes it is bound to bsc_strap_capture and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module bsc_strap_capture_checker
   import bsc_pkg::*;
#(
   parameter int WIDTH = STRAP_W
)
(
   // clock, resets and strap control
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] strap_input_bus,
   input wire logic strap_sample_clock,
   input wire logic strap_clear_n,
   input wire logic chip_reset_n,
   input wire logic psel,
   // configuration outputs
   input wire logic vector_base_high_sel,
   input wire logic [31:0] vector_base_addr,
   input wire logic big_endian_init_sel,
   input wire logic fp_coproc_enable,
   input wire logic multiport_static_sel,
   input wire logic static_alias_enable,
   input wire logic dynamic_alias_enable,
   input wire logic [1:0] alias_target,
   input wire logic bridge_map_sel,
   input wire logic use_pll_sel,
   input wire logic pll_bypass_sel,
   input wire logic pll_short_feedback_sel,
   input wire logic [1:0] bus_clock_div_sel,
   input wire logic [2:0] bus_clock_divisor,
   input wire logic [2:0] strap_misc_low,
   input wire logic [13:0] strap_misc_high,
   input wire logic config_in_force
);
   wire logic [28:0] store = {strap_misc_high, bus_clock_div_sel, pll_short_feedback_sel,
      pll_bypass_sel, use_pll_sel, strap_misc_low, bridge_map_sel, dynamic_alias_enable,
      static_alias_enable, multiport_static_sel, fp_coproc_enable, big_endian_init_sel,
      vector_base_high_sel};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   a_reset_default: assert property ($rose(reset_n) |-> store == STRAP_RESET)
      else $error("store not at default after reset");
   a_capture_pads: assert property ($rose(strap_sample_clock) && !chip_reset_n ##1
      strap_clear_n |=> store == $past(strap_input_bus))
      else $error("capture did not load pads");
   a_clear_store: assert property (!strap_clear_n |=> store == STRAP_RESET)
      else $error("clear did not restore defaults");
   a_hold_store: assert property (!$rose(strap_sample_clock) ##1
      strap_clear_n && !psel |=> $stable(store))
      else $error("store changed without cause");
   a_vector_base: assert property ($stable(vector_base_high_sel) |->
      vector_base_addr == (vector_base_high_sel ? VEC_BASE_HIGH : VEC_BASE_LOW))
      else $error("vector base address wrong");
   a_bus_divisor: assert property ($stable(bus_clock_div_sel) |->
      bus_clock_divisor == {1'b0, bus_clock_div_sel} + 3'h1)
      else $error("bus divisor wrong");
   a_alias_map: assert property ($stable({dynamic_alias_enable, static_alias_enable})
      |-> alias_target == {dynamic_alias_enable, static_alias_enable})
      else $error("alias target wrong");
   a_mode_in_force: assert property ($rose(chip_reset_n) |->
      !config_in_force ##1 config_in_force)
      else $error("mode not in force after chip reset");
endmodule
bind bsc_strap_capture bsc_strap_capture_checker #(.WIDTH(WIDTH)) i_chk (.*);
`default_nettype wire

// >>> tb.sv
/*
 self-checking bench for the strap capture block.
 assumes the strap source model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
   import bsc_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, clr_n = 1'b1, chip_n = 1'b0, go = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, rd, vaddr;
   logic [28:0] want = 29'h0000000, pads;
   logic strobe, pready, pslverr, vhi, be, fp, mp, st, dy, br, up, byp, sfb, force_on;
   logic [1:0] alias_t, dsel;
   logic [2:0] divisor, mlo;
   logic [13:0] mhi;
   int failures = 0, comparisons = 0, cycles = 0;
   wire logic [28:0] store = {mhi, dsel, sfb, byp, up, mlo, br, dy, st, mp, fp, be, vhi};
   bsc_strap_source i_src (.clk(clk), .reset_n(reset_n), .go(go), .want(want),
      .pads(pads), .strobe(strobe));
   bsc_strap_capture i_dut (.clk(clk), .reset_n(reset_n), .strap_input_bus(pads),
      .strap_sample_clock(strobe), .strap_clear_n(clr_n), .chip_reset_n(chip_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .vector_base_high_sel(vhi), .vector_base_addr(vaddr),
      .big_endian_init_sel(be), .fp_coproc_enable(fp), .multiport_static_sel(mp),
      .static_alias_enable(st), .dynamic_alias_enable(dy), .alias_target(alias_t),
      .bridge_map_sel(br), .use_pll_sel(up), .pll_bypass_sel(byp),
      .pll_short_feedback_sel(sfb), .bus_clock_div_sel(dsel), .bus_clock_divisor(divisor),
      .strap_misc_low(mlo), .strap_misc_high(mhi), .config_in_force(force_on));
   initial forever #5 clk = ~clk;
   task automatic print_verdict();
      if (failures == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic check_cfg(input logic [28:0] e);
      check("store", {3'h0, store}, {3'h0, e});
      check("vector base", vaddr, e[0] ? VEC_BASE_HIGH : VEC_BASE_LOW);
      check("divisor", {29'h0, divisor}, {29'h0, 3'(e[14:13]) + 3'h1});
      check("alias", {30'h0, alias_t}, {30'h0, e[5:4]});
   endtask
   // idle cycle after each transfer so psel is never driven twice in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic frame(input logic [28:0] v);
      want <= v;
      go <= 1'b1;
      @(posedge clk) go <= 1'b0;
      repeat (9) @(posedge clk);
   endtask
   task automatic s_capture();
      logic [28:0] pat [3] = '{29'h1FFFFFFF, 29'h0000000, 29'h0005010};
      foreach (pat[i]) begin
         frame(pat[i]);
         check_cfg(pat[i]);
      end
   endtask
   task automatic s_regs();
      logic [28:0] inv;
      inv = ~29'h0005010 & ~29'h0000020 | 29'h0000010;
      apb(1'b0, OFS_PADS, 32'h0, rd, err);
      check("pads reg", rd, {3'h0, inv});
      apb(1'b1, OFS_CTRL, 32'h2, rd, err);
      repeat (2) @(posedge clk);
      check_cfg(inv);
      apb(1'b0, OFS_CAPTURED, 32'h0, rd, err);
      check("captured reg", rd, {3'h0, inv});
      apb(1'b1, 8'h10, 32'h4, rd, err);
      check("unmapped", {31'h0, err}, 32'h1);
      check_cfg(inv);
      apb(1'b1, OFS_CTRL, 32'h4, rd, err);
      repeat (2) @(posedge clk);
      check_cfg(STRAP_RESET);
      // four captures so far; clear drops taken but keeps the count
      apb(1'b0, OFS_STATUS, 32'h0, rd, err);
      check("status", rd, (32'h4 << STAT_CNT_LO) | (32'h1 << STAT_IN_RST));
   endtask
   task automatic s_running();
      chip_n <= 1'b1;
      repeat (2) @(posedge clk);
      check("in force", {31'h0, force_on}, 32'h1);
      frame(29'h1FFFFFFF);
      check_cfg(STRAP_RESET);
      // live mode lets a strobe through while the chip runs
      apb(1'b1, OFS_CTRL, 32'h1, rd, err);
      frame(29'h0000000);
      check_cfg(29'h0000000);
      apb(1'b0, OFS_STATUS, 32'h0, rd, err);
      check("status live", rd, (32'h5 << STAT_CNT_LO) | (32'h1 << STAT_TAKEN));
      apb(1'b1, OFS_CTRL, 32'h0, rd, err);
      chip_n <= 1'b0;
   endtask
   task automatic s_clear_pin();
      frame(29'h0000000);
      clr_n <= 1'b0;
      @(posedge clk) clr_n <= 1'b1;
      @(posedge clk);
      check_cfg(STRAP_RESET);
   endtask
   // own reset in mid run drops a captured mode back to defaults
   task automatic s_own_reset();
      frame(29'h1FFFFFFF);
      check_cfg(29'h1FFFFFFF);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      check_cfg(STRAP_RESET);
      apb(1'b0, OFS_STATUS, 32'h0, rd, err);
      check("status reset", rd, 32'h1 << STAT_IN_RST);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      check_cfg(STRAP_RESET);
      check("in force", {31'h0, force_on}, 32'h0);
      s_capture();
      s_regs();
      s_running();
      s_clear_pin();
      s_own_reset();
      print_verdict();
   end
endmodule
`default_nettype wire
